// File: rtl/spc_pkg.sv
// package: register map, field layout, reset values and state codes of the serial pin block
package spc_pkg;

  // ==========================================================
  // register byte addresses
  // ==========================================================
  localparam logic [31:0] SPC_ADDR_OD = 32'h000F_0050;    // open-drain select
  localparam logic [31:0] SPC_ADDR_NF = 32'h000F_0070;    // receive noise filter
  localparam logic [31:0] SPC_ADDR_INV = 32'h000F_0134;   // transmit level inversion
  localparam logic [31:0] SPC_ADDR_ROUTE = 32'h00F0_0730; // receive input routing
  localparam logic [31:0] SPC_ADDR_DIR = 32'h000F_FF20;   // port direction
  localparam logic [31:0] SPC_ADDR_PMC = 32'h000F_FF40;   // port mode control
  localparam logic [31:0] SPC_ADDR_LATCH = 32'h000F_FF00; // port output latch
  localparam logic [31:0] SPC_ADDR_STAT = 32'h000F_FF80;  // pin and receive status

  // ==========================================================
  // port geometry and field positions
  // ==========================================================
  localparam int SPC_NPINS = 5;     // pins of the shared port
  localparam int SPC_PIN_TX = 0;    // pin shared with serial data out
  localparam int SPC_PIN_RX = 1;    // pin shared with uart receive
  localparam int SPC_BIT_EXT = 0;   // routing: receive to interrupt input
  localparam int SPC_BIT_TMR = 1;   // routing: receive to timer channel 1
  localparam int SPC_STAT_PIN = 8;  // status: pin levels start here
  localparam int SPC_STAT_CHEN = 1; // status: channel enable bit

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic SPC_RST_BIT = 1'h0;            // single control bits
  localparam logic [1:0] SPC_RST_ROUTE = 2'h0;    // routing field
  localparam logic [4:0] SPC_RST_DIR = 5'h1F;     // all pins input
  localparam logic [4:0] SPC_RST_PMC = 5'h00;     // mode control
  localparam logic [4:0] SPC_RST_LATCH = 5'h00;   // output latch
  localparam logic [2:0] SPC_DIR_FIXED = 3'h7;    // unimplemented direction bits
  localparam logic [4:0] SPC_RST_PINS = 5'h00;    // pin drivers and samplers
  localparam logic SPC_RX_IDLE = 1'h1;            // idle level of the receive line
  localparam logic [31:0] SPC_RST_WORD = 32'h0000_0000; // bus words

  // ==========================================================
  // timing
  // ==========================================================
  localparam int unsigned SPC_MCK_DIV_DEF = 2; // hclk cycles per operating clock

  // ==========================================================
  // bus phase tracker, one-hot
  // ==========================================================
  typedef enum logic [2:0] {
    SPC_BUS_IDLE = 3'b001,  // no data phase pending
    SPC_BUS_WDATA = 3'b010, // write data phase
    SPC_BUS_RWAIT = 3'b100  // read wait state
  } spc_bus_t;

endpackage

// File: rtl/spc_rx_filter.sv
// receive conditioning: two-flop synchroniser and two-sample level qualifier
`timescale 1ns/100ps

module spc_rx_filter
  import spc_pkg::*;
(
  input wire logic clk,       // block clock
  input wire logic rst_n,     // async reset, active low
  input wire logic pin_async, // raw receive pin
  input wire logic sample_en, // operating clock pulse
  input wire logic filter_en, // level qualifier on
  output logic level_q        // conditioned receive level
);

  logic meta_q; // first synchroniser stage
  logic sync_q; // second synchroniser stage
  logic samp_q; // previous operating-clock sample

  // ==========================================================
  // synchroniser
  // ==========================================================
  // two flops before anything looks at the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= SPC_RX_IDLE;
      sync_q <= SPC_RX_IDLE;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
    end
  end

  // ==========================================================
  // qualifier
  // ==========================================================
  // keep the last operating-clock sample for comparison
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= SPC_RX_IDLE;
    end else if (sample_en) begin
      samp_q <= sync_q;
    end
  end

  // output level, updated only on operating clock pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= SPC_RX_IDLE;
    end else if (sample_en) begin
      if (!filter_en) begin
        level_q <= sync_q; // plain synchronised pass
      end else if (sync_q == samp_q) begin
        level_q <= sync_q; // two agreeing samples
      end else begin
        level_q <= level_q; // samples disagree: hold
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence agree_s;
    sample_en && filter_en && (sync_q == samp_q);
  endsequence

  filt_accept_a: assert property (
    agree_s |=> level_q == $past(samp_q))
    else $error("filtered level ignores two agreeing samples");

  filt_hold_a: assert property (
    sample_en && filter_en && (sync_q != samp_q) |=> $stable(level_q))
    else $error("filtered level moved on disagreeing samples");

  nofilt_pass_a: assert property (
    sample_en && !filter_en |=> level_q == $past(sync_q))
    else $error("unfiltered level is not the synchronised pin");

endmodule // spc_rx_filter

// File: rtl/spc_top.sv
// top: serial pin conditioning with an ahb-lite register slave
`timescale 1ns/100ps

// Functional notes
// - invert tx data when invert bit set
// - inversion only while serial output enabled
// - filter syncs, then needs two equal samples
// - filter off passes synchronised input only
// - filter bit zero controls, others read zero
// - routing bit zero feeds rx to interrupt
// - routing bit one feeds rx to timer
// - open-drain bit selects n-channel output buffer
// - direction register resets to all ones
// - direction register takes whole byte writes
// - routing register byte writes, resets zero
// - filter register resets to zero
// - open-drain register resets zero, byte writes
module spc_top
  import spc_pkg::*;
#(
  parameter int unsigned MCK_DIV = SPC_MCK_DIV_DEF // hclk cycles per operating clock
) (
  input wire logic hclk,                        // bus and block clock
  input wire logic hresetn,                     // async reset, active low
  input wire logic hsel,                        // slave select
  input wire logic [31:0] haddr,                // byte address
  input wire logic [1:0] htrans,                // transfer type
  input wire logic hwrite,                      // write when high
  input wire logic [2:0] hsize,                 // transfer size
  input wire logic [31:0] hwdata,               // write data
  input wire logic hready,                      // bus ready in
  output logic hreadyout,                       // slave ready
  output logic [31:0] hrdata,                   // read data
  output logic hresp,                           // response, always okay
  input wire logic [SPC_NPINS-1:0] pin_in,      // port pin levels
  output logic [SPC_NPINS-1:0] pin_out,         // port pin drive value
  output logic [SPC_NPINS-1:0] pin_oe,          // port pin drive enable
  input wire logic ext_irq_pin,                 // dedicated interrupt pin
  input wire logic timer_ch1_input_pin,         // dedicated timer pin
  input wire logic serial_tx_data,              // engine transmit data
  input wire logic serial_output_enable,        // engine owns the data pin
  input wire logic serial_output_latch,         // software data level
  input wire logic channel_enable_status,       // channel running
  output logic rx_data,                         // conditioned receive level
  output logic ext_irq_input,                   // to external interrupt
  output logic timer_ch1_input,                 // to timer channel 1
  output logic channel_operating_clock          // operating clock pulse
);

  // ==========================================================
  // declarations
  // ==========================================================
  spc_bus_t state_q;          // bus phase tracker
  logic [31:0] addr_q;        // latched address phase
  logic hreadyout_q;          // registered ready
  logic [31:0] hrdata_q;      // registered read data
  logic hresp_q;              // registered response
  logic [31:0] rd_mux;        // read data selected by address
  logic take;                 // address phase accepted
  logic wr_go;                // write data phase now
  logic [7:0] wbyte;          // write byte lane
  logic od_q;                 // open-drain select
  logic nf_q;                 // receive noise filter enable
  logic inv_q;                // transmit level invert
  logic [1:0] route_q;        // receive routing
  logic [SPC_NPINS-1:0] dir_q;   // port direction
  logic [SPC_NPINS-1:0] pmc_q;   // port mode control
  logic [SPC_NPINS-1:0] latch_q; // port output latch
  logic [SPC_NPINS-1:0] pin_meta_q; // pin sync first stage
  logic [SPC_NPINS-1:0] pin_sync_q; // pin sync second stage
  logic ext_meta_q;           // interrupt pin first stage
  logic ext_sync_q;           // interrupt pin second stage
  logic tmr_meta_q;           // timer pin first stage
  logic tmr_sync_q;           // timer pin second stage
  logic [7:0] mck_cnt_q;      // operating clock divider
  logic mck_en_q;             // operating clock pulse
  logic rx_level;             // conditioned receive level
  logic ext_q;                // routed interrupt input
  logic tmr_q;                // routed timer input
  logic tx_level;             // data pin level after inversion stage
  logic tx_val;               // value aimed at the data pin
  logic drv_tx;               // data pin set up for output
  logic [SPC_NPINS-1:0] pin_out_q; // pin drive values
  logic [SPC_NPINS-1:0] pin_oe_q;  // pin drive enables

  // ==========================================================
  // bus front end
  // ==========================================================
  assign take = hsel && hready && htrans[1];
  assign wr_go = (state_q == SPC_BUS_WDATA);
  assign wbyte = hwdata[7:0];

  // address capture and phase sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= SPC_BUS_IDLE;
      addr_q <= SPC_RST_WORD;
    end else begin
      case (state_q)
        SPC_BUS_RWAIT: begin
          state_q <= SPC_BUS_IDLE; // read answer lands now
        end
        SPC_BUS_IDLE, SPC_BUS_WDATA: begin
          if (take) begin
            addr_q <= haddr;
            state_q <= hwrite ? SPC_BUS_WDATA : SPC_BUS_RWAIT;
          end else begin
            state_q <= SPC_BUS_IDLE;
          end
        end
        default: begin
          state_q <= SPC_BUS_IDLE; // recover from a bad code
        end
      endcase
    end
  end

  // ready: one wait state on reads so data comes from registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'h1;
    end else if (state_q == SPC_BUS_RWAIT) begin
      hreadyout_q <= 1'h1;
    end else if (take && !hwrite) begin
      hreadyout_q <= 1'h0;
    end
  end

  // read data register and fixed okay response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= SPC_RST_WORD;
      hresp_q <= 1'h0;
    end else begin
      hresp_q <= 1'h0;
      if (state_q == SPC_BUS_RWAIT) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_mux = SPC_RST_WORD;
    case (addr_q)
      SPC_ADDR_OD: rd_mux = {31'h0000_0000, od_q};
      SPC_ADDR_NF: rd_mux = {31'h0000_0000, nf_q};
      SPC_ADDR_INV: rd_mux = {31'h0000_0000, inv_q};
      SPC_ADDR_ROUTE: rd_mux = {30'h0000_0000, route_q};
      SPC_ADDR_DIR: rd_mux = {24'h00_0000, SPC_DIR_FIXED, dir_q};
      SPC_ADDR_PMC: rd_mux = {27'h000_0000, pmc_q};
      SPC_ADDR_LATCH: rd_mux = {27'h000_0000, latch_q};
      SPC_ADDR_STAT: begin
        rd_mux[SPC_STAT_PIN +: SPC_NPINS] = pin_sync_q;
        rd_mux[SPC_STAT_CHEN] = channel_enable_status;
        rd_mux[0] = rx_level;
      end
      default: rd_mux = SPC_RST_WORD;
    endcase
  end

  // ==========================================================
  // serial control registers
  // ==========================================================
  // single control bits; unused positions are not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      od_q <= SPC_RST_BIT;
      nf_q <= SPC_RST_BIT;
      inv_q <= SPC_RST_BIT;
    end else if (wr_go) begin
      if (addr_q == SPC_ADDR_OD) begin
        od_q <= wbyte[0];
      end
      if (addr_q == SPC_ADDR_NF) begin
        nf_q <= wbyte[0];
      end
      if (addr_q == SPC_ADDR_INV) begin
        inv_q <= wbyte[0]; // held still by software while running
      end
    end
  end

  // receive routing field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_q <= SPC_RST_ROUTE;
    end else if (wr_go && addr_q == SPC_ADDR_ROUTE) begin
      route_q <= wbyte[1:0];
    end
  end

  // ==========================================================
  // port registers
  // ==========================================================
  // direction, mode control and latch: whole-byte writes only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= SPC_RST_DIR;
      pmc_q <= SPC_RST_PMC;
      latch_q <= SPC_RST_LATCH;
    end else if (wr_go) begin
      if (addr_q == SPC_ADDR_DIR) begin
        dir_q <= wbyte[SPC_NPINS-1:0];
      end
      if (addr_q == SPC_ADDR_PMC) begin
        pmc_q <= wbyte[SPC_NPINS-1:0];
      end
      if (addr_q == SPC_ADDR_LATCH) begin
        latch_q <= wbyte[SPC_NPINS-1:0];
      end
    end
  end

  // ==========================================================
  // pin input synchronisers
  // ==========================================================
  // two flops on every asynchronous input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_q <= SPC_RST_PINS;
      pin_sync_q <= SPC_RST_PINS;
      ext_meta_q <= 1'h0;
      ext_sync_q <= 1'h0;
      tmr_meta_q <= 1'h0;
      tmr_sync_q <= 1'h0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      ext_meta_q <= ext_irq_pin;
      ext_sync_q <= ext_meta_q;
      tmr_meta_q <= timer_ch1_input_pin;
      tmr_sync_q <= tmr_meta_q;
    end
  end

  // ==========================================================
  // operating clock and receive path
  // ==========================================================
  // divider: one-cycle pulse every MCK_DIV hclk cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mck_cnt_q <= 8'h00;
      mck_en_q <= 1'h0;
    end else if (mck_cnt_q >= 8'(MCK_DIV - 1)) begin
      mck_cnt_q <= 8'h00;
      mck_en_q <= 1'h1;
    end else begin
      mck_cnt_q <= mck_cnt_q + 8'h01;
      mck_en_q <= 1'h0;
    end
  end

  // synchroniser and optional qualifier on the receive pin
  spc_rx_filter u_rx_filter (
    .clk(hclk),
    .rst_n(hresetn),
    .pin_async(pin_in[SPC_PIN_RX]),
    .sample_en(mck_en_q),
    .filter_en(nf_q),
    .level_q(rx_level)
  );

  // routing of the receive level to interrupt and timer inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'h0;
      tmr_q <= 1'h0;
    end else begin
      ext_q <= route_q[SPC_BIT_EXT] ? rx_level : ext_sync_q;
      tmr_q <= route_q[SPC_BIT_TMR] ? rx_level : tmr_sync_q;
    end
  end

  // ==========================================================
  // transmit path and pin drivers
  // ==========================================================
  assign tx_level = serial_output_enable ? (serial_tx_data ^ inv_q)
    : serial_output_latch; // inversion applies only to engine data
  // latch must hold one for the serial level to pass
  assign tx_val = latch_q[SPC_PIN_TX] && tx_level;
  assign drv_tx = !dir_q[SPC_PIN_TX] && !pmc_q[SPC_PIN_TX];

  // registered drive value and enable for every pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= SPC_RST_PINS;
      pin_oe_q <= SPC_RST_PINS;
    end else begin
      for (int i = 0; i < SPC_NPINS; i++) begin
        pin_out_q[i] <= latch_q[i];
        pin_oe_q[i] <= !dir_q[i] && !pmc_q[i]; // direction 1 releases
      end
      if (od_q) begin
        pin_out_q[SPC_PIN_TX] <= 1'h0; // n-channel: pull low only
        pin_oe_q[SPC_PIN_TX] <= drv_tx && !tx_val;
      end else begin
        pin_out_q[SPC_PIN_TX] <= tx_val; // push-pull
        pin_oe_q[SPC_PIN_TX] <= drv_tx;
      end
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign rx_data = rx_level;
  assign ext_irq_input = ext_q;
  assign timer_ch1_input = tmr_q;
  assign channel_operating_clock = mck_en_q;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_nf_s;
    take && !hwrite && haddr == SPC_ADDR_NF ##1 !hreadyout_q;
  endsequence

  sequence wr_dir_s;
    take && hwrite && haddr == SPC_ADDR_DIR ##1 hready;
  endsequence

  sequence wr_route_s;
    take && hwrite && haddr == SPC_ADDR_ROUTE ##1 hready;
  endsequence

  tx_invert_a: assert property (
    serial_output_enable && drv_tx && !od_q && latch_q[SPC_PIN_TX]
    |=> pin_out_q[SPC_PIN_TX] == ($past(serial_tx_data) ^ $past(inv_q)))
    else $error("data pin ignores inversion setting");

  tx_bypass_a: assert property (
    !serial_output_enable && drv_tx && !od_q && latch_q[SPC_PIN_TX]
    |=> pin_out_q[SPC_PIN_TX] == $past(serial_output_latch) && pin_oe_q[SPC_PIN_TX])
    else $error("data pin not the software level when output disabled");

  od_buffer_a: assert property (
    drv_tx && od_q
    |=> !pin_out_q[SPC_PIN_TX] && (pin_oe_q[SPC_PIN_TX] == !$past(tx_val)))
    else $error("open-drain pin drives high or misses low");

  ext_route_a: assert property (
    route_q[SPC_BIT_EXT] && $stable(route_q) |=> ext_q == $past(rx_level))
    else $error("interrupt input not fed from receive pin");

  tmr_route_a: assert property (
    !route_q[SPC_BIT_TMR] |=> tmr_q == $past(tmr_sync_q))
    else $error("timer input not fed from its own pin");

  dir_reset_a: assert property (
    $rose(hresetn) |-> dir_q == SPC_RST_DIR && pin_oe_q == SPC_RST_PINS)
    else $error("direction not all inputs after reset");

  nf_reset_a: assert property (
    $rose(hresetn) |-> !nf_q && !od_q && route_q == SPC_RST_ROUTE)
    else $error("control registers not clear after reset");

  nf_read_a: assert property (
    rd_nf_s |=> hreadyout_q && hrdata_q[31:1] == 31'h0000_0000 && hrdata_q[0] == nf_q)
    else $error("filter register read shows stray bits");

  dir_write_a: assert property (
    wr_dir_s |=> dir_q == $past(hwdata[SPC_NPINS-1:0]))
    else $error("direction byte write not stored");

  route_write_a: assert property (
    wr_route_s |=> route_q == $past(hwdata[1:0]))
    else $error("routing byte write not stored");

endmodule // spc_top

// File: sim/spc_line_model.sv
// far-side model: pin wires with pull-ups and the incoming uart line
`timescale 1ns/100ps

module spc_line_model
  import spc_pkg::*;
(
  input wire logic [SPC_NPINS-1:0] pin_out, // device drive value
  input wire logic [SPC_NPINS-1:0] pin_oe,  // device drive enable
  input wire logic rx_line,                 // far transmitter level
  output logic [SPC_NPINS-1:0] pin_in       // resolved pin levels
);
  // ==========================================================
  // wire resolution
  // ==========================================================
  // released pins go to the pull-up, the receive pin follows the far transmitter
  always_comb begin
    for (int i = 0; i < SPC_NPINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ((i == SPC_PIN_RX) ? rx_line : 1'h1);
    end
  end
endmodule // spc_line_model

// File: sim/spc_top_tb.sv
// self-checking bench for the serial pin conditioning block
`timescale 1ns/100ps
`define CHK(a, e) begin \
  checks++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); \
  end \
end

module spc_top_tb;
  import spc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_line, ext_pin, tmr_pin; // bus and lines
  logic tx_data, soe, sol, ches, rx_data, ext_irq_input, timer_ch1_input, mck; // engine side
  logic [31:0] haddr, hwdata, hrdata, rd; // bus words
  logic [1:0] htrans; // transfer type
  logic [2:0] hsize; // always word
  logic [SPC_NPINS-1:0] pin_in, pin_out, pin_oe; // port pins
  int errors, checks, cycles, lows; // counters

  spc_top #(.MCK_DIV(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_irq_pin(ext_pin), .timer_ch1_input_pin(tmr_pin),
    .serial_tx_data(tx_data), .serial_output_enable(soe), .serial_output_latch(sol),
    .channel_enable_status(ches), .rx_data(rx_data), .ext_irq_input(ext_irq_input),
    .timer_ch1_input(timer_ch1_input), .channel_operating_clock(mck));
  spc_line_model u_line (.pin_out(pin_out), .pin_oe(pin_oe), .rx_line(rx_line), .pin_in(pin_in));

  // ==========================================================
  // clock, timeout, bus tasks
  // ==========================================================
  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end
  // cut a hang short well past the expected few hundred cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end
  // one single ahb transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // read and compare one register
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(hresp, 1'h0)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  // reset values, unmapped read, field masking
  task automatic t_regs();
    rchk(SPC_ADDR_OD, 32'h0000_0000);
    rchk(SPC_ADDR_NF, 32'h0000_0000);
    rchk(SPC_ADDR_ROUTE, 32'h0000_0000);
    rchk(SPC_ADDR_DIR, 32'h0000_00FF);
    rchk(32'h000F_0000, 32'h0000_0000);
    bus(1'h1, SPC_ADDR_NF, 32'h0000_0001); // unused bits written zero
    rchk(SPC_ADDR_NF, 32'h0000_0001);
    bus(1'h1, SPC_ADDR_ROUTE, 32'h0000_0003);
    rchk(SPC_ADDR_ROUTE, 32'h0000_0003);
    bus(1'h1, SPC_ADDR_DIR, 32'h0000_0000);
    rchk(SPC_ADDR_DIR, 32'h0000_00E0);
    bus(1'h1, SPC_ADDR_OD, 32'h0000_0001);
    rchk(SPC_ADDR_OD, 32'h0000_0001);
    bus(1'h1, SPC_ADDR_OD, 32'h0000_0000);
    bus(1'h1, SPC_ADDR_NF, 32'h0000_0000); // filter off for clocked serial use
    bus(1'h1, SPC_ADDR_ROUTE, 32'h0000_0000);
    $display("test regs done");
  endtask
  // transmit level inversion and output buffer mode on the data pin
  task automatic t_tx();
    logic [2:0] k; // invert, enable, data
    bus(1'h1, SPC_ADDR_DIR, 32'h0000_001E);
    bus(1'h1, SPC_ADDR_LATCH, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      soe <= k[1];
      tx_data <= k[0];
      sol <= ~k[0];
      bus(1'h1, SPC_ADDR_INV, {31'h0, k[2]}); // channel stopped
      tick(3);
      `CHK(pin_out[0], k[1] ? k[0] ^ k[2] : ~k[0])
      `CHK(pin_oe[0], 1'h1)
    end
    `CHK(pin_oe, 5'h01)
    `CHK(pin_out[4:1], 4'h0)
    soe <= 1'h0;
    bus(1'h1, SPC_ADDR_OD, 32'h0000_0001);
    for (int j = 0; j < 2; j++) begin
      sol <= j[0];
      tick(3);
      `CHK(pin_oe[0], ~j[0])
      `CHK(pin_in[0], j[0])
    end
    bus(1'h1, SPC_ADDR_OD, 32'h0000_0000);
    $display("test tx done");
  endtask
  // receive synchroniser, glitch filter and input routing
  task automatic t_rx();
    rx_line <= 1'h0;
    tick(10);
    `CHK(rx_data, 1'h0)
    rx_line <= 1'h1;
    tick(10);
    bus(1'h1, SPC_ADDR_NF, 32'h0000_0001); // filter on for uart receive
    rx_line <= 1'h0;
    tick(2);
    rx_line <= 1'h1;
    lows = 0;
    repeat (12) begin
      @(posedge hclk);
      if (rx_data !== 1'h1) lows++;
    end
    `CHK(lows, 0)
    rx_line <= 1'h0;
    tick(12);
    `CHK(rx_data, 1'h0)
    ext_pin <= 1'h1;
    tmr_pin <= 1'h1;
    for (int r = 0; r < 4; r++) begin
      bus(1'h1, SPC_ADDR_ROUTE, r);
      tick(3);
      `CHK(ext_irq_input, ~r[0])
      `CHK(timer_ch1_input, ~r[1])
    end
    // operating clock: one pulse every two hclk cycles
    lows = 0;
    repeat (8) begin
      @(posedge hclk);
      lows += mck;
    end
    `CHK(lows, 4)
    // status: pins 11101, channel running, receive level low
    ches <= 1'h1;
    rchk(SPC_ADDR_STAT, 32'h0000_1D02);
    $display("test rx done");
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    hresetn = 1'h0;
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'h0, 1'h0, 2'h0, 32'h0, 32'h0, 3'h2};
    {rx_line, ext_pin, tmr_pin, tx_data, soe, sol, ches} = 7'h40;
    {errors, checks, cycles} = {32'h0, 32'h0, 32'h0};
    tick(10);
    hresetn <= 1'h1;
    t_regs();
    t_tx();
    t_rx();
    stop_test();
  end
endmodule // spc_top_tb
